// ===== bench/uart_rx_line_status_tb_top.sv
// self-checking bench of the receive line status block
`include "ulsr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_rx_line_status_tb_top;
    localparam int LIMIT = 3000;                    // cycles before the run is cut
    localparam logic [31:0] DR = 32'h1 << `ULSR_BIT_DR;
    localparam logic [31:0] OE = 32'h1 << `ULSR_BIT_OE;
    localparam logic [31:0] PE = 32'h1 << `ULSR_BIT_PE;
    logic        clk, rst, wrStb, rdStb, rdPend;   // clock, reset, strobes
    logic [3:0]  addr;                              // register address
    logic [31:0] wrData, rdData;                    // bus data
    logic [7:0]  modemStatus, d, d2;                // modem value, characters
    logic [7:0]  chars [5];                         // burst for the full store
    logic        rxValid, rxParityErr, rxFrameErr, rxBreak;
    logic [7:0]  rxData;
    logic        irq, rxDataIrq, lineStatusIrq;
    logic [31:0] expQ [$];                          // expected read data, oldest first
    int          errTotal, numChecks, cycles, seed;

    // small store depth keeps the overrun burst short
    ulsr_line_status #(.FIFO_DEPTH(4)) dut_u (
        .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .rxValid(rxValid), .rxData(rxData),
        .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr), .rxBreak(rxBreak),
        .modemStatus(modemStatus), .irq(irq), .rxDataIrq(rxDataIrq),
        .lineStatusIrq(lineStatusIrq));
    ulsr_rx_source src_u (
        .clk(clk), .rxValid(rxValid), .rxData(rxData), .rxParityErr(rxParityErr),
        .rxFrameErr(rxFrameErr), .rxBreak(rxBreak));

    // 50 ns period
    always #25 clk = ~clk;

    task automatic chkWord(input logic [31:0] e, input logic [31:0] s);
        numChecks++;
        if (s !== e) begin
            errTotal++;
            $display("mismatch rdData expected %h seen %h", e, s);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, input logic s);
        numChecks++;
        if (s !== e) begin
            errTotal++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask
    // each bus task sets both strobes once, so back-to-back cycles never double-assign
    task automatic regWr(input logic [3:0] a, input logic [31:0] v);
        addr <= a;
        wrData <= v;
        wrStb <= 1'b1;
        rdStb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic regRd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        addr <= a;
        wrStb <= 1'b0;
        rdStb <= 1'b1;
        @(posedge clk);
    endtask
    // idle(0) only lowers the strobes, so a held access is not repeated
    task automatic idle(input int n);
        wrStb <= 1'b0;
        rdStb <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic chkIrqs(input logic i, input logic r, input logic l);
        chkBit("irq", i, irq);
        chkBit("rxDataIrq", r, rxDataIrq);
        chkBit("lineStatusIrq", l, lineStatusIrq);
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", errTotal, numChecks);
        if (errTotal == 0 && numChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe, so compare there
    always @(posedge clk) begin
        rdPend <= rdStb;
        if (rdPend)
            chkWord(expQ.pop_front(), rdData);
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errTotal++;
            give_verdict();
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {addr, wrData, wrStb, rdStb, rdPend} = '0;
        modemStatus = 8'h00;
        {errTotal, numChecks, cycles} = '0;
        seed = 32'hF6D5;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        modemStatus <= 8'($random(seed));
        @(posedge clk);
        // reset values, modem status, unmapped place, read-only status
        regRd(`ULSR_OFS_LSTAT, 32'h0);
        regRd(`ULSR_OFS_IRQEN, 32'h0);
        regRd(`ULSR_OFS_MODEM, {24'h0, modemStatus});
        regRd(4'h7, 32'h0);
        regWr(`ULSR_OFS_LSTAT, 32'hFFFFFFFF);
        regRd(`ULSR_OFS_LSTAT, 32'h0);
        // single character with bad parity, then read it out
        d = 8'($random(seed));
        idle(0);
        src_u.send(d, 3'h4, 1);
        regRd(`ULSR_OFS_LSTAT, DR | PE);
        regRd(`ULSR_OFS_RXBUF, {24'h0, d});
        regRd(`ULSR_OFS_LSTAT, 32'h0);
        // overwrite of an unread character
        d2 = 8'($random(seed));
        idle(0);
        src_u.send(d, 3'h0, 1);
        src_u.send(d2, 3'h0, 1);
        regRd(`ULSR_OFS_LSTAT, DR | OE);
        regRd(`ULSR_OFS_LSTAT, DR);
        regRd(`ULSR_OFS_RXBUF, {24'h0, d2});
        // interrupts raised, cleared, then masked
        regWr(`ULSR_OFS_IRQEN, 32'h5);
        regWr(`ULSR_OFS_EVEN, 32'h1 << `ULSR_EV_RXCHAR);
        idle(0);
        src_u.send(d, 3'h4, 1);
        idle(3);
        chkIrqs(1'b1, 1'b1, 1'b1);
        // char, overrun from the overwrite above, parity: all still sticky
        regRd(`ULSR_OFS_EVSTAT, 32'h7);
        regWr(`ULSR_OFS_EVCLR, 32'h7);
        regRd(`ULSR_OFS_RXBUF, {24'h0, d});
        idle(3);
        chkIrqs(1'b0, 1'b0, 1'b0);
        regWr(`ULSR_OFS_IRQEN, 32'h0);
        regWr(`ULSR_OFS_EVEN, 32'h0);
        idle(0);
        src_u.send(d2, 3'h4, 1);
        idle(3);
        chkIrqs(1'b0, 1'b0, 1'b0);
        // store mode: parity follows the head character
        regWr(`ULSR_OFS_FIFOCTL, 32'h1);
        idle(0);
        src_u.send(d, 3'h4, 0);
        src_u.send(d2, 3'h0, 1);
        regRd(`ULSR_OFS_LSTAT, DR | PE);
        regRd(`ULSR_OFS_RXBUF, {24'h0, d});
        regRd(`ULSR_OFS_LSTAT, DR);
        regRd(`ULSR_OFS_RXBUF, {24'h0, d2});
        regRd(`ULSR_OFS_LSTAT, 32'h0);
        // full store plus one more: overrun at once, extra character dropped
        idle(0);
        for (int i = 0; i < 5; i++) begin
            chars[i] = 8'($random(seed));
            src_u.send(chars[i], 3'h0, (i == 4) ? 1 : 0);
        end
        regRd(`ULSR_OFS_LSTAT, DR | OE);
        for (int i = 0; i < 4; i++)
            regRd(`ULSR_OFS_RXBUF, {24'h0, chars[i]});
        regRd(`ULSR_OFS_LSTAT, 32'h0);
        idle(3);
        give_verdict();
    end
endmodule
`default_nettype wire

// ===== bench/ulsr_rx_source.sv
// remote character source feeding the receive side of the status block
`timescale 1ns/1ps
`default_nettype none
module ulsr_rx_source (
    input  wire logic       clk,
    output logic            rxValid,
    output logic      [7:0] rxData,
    output logic            rxParityErr,
    output logic            rxFrameErr,
    output logic            rxBreak
);
    // idle lines start from a plain pattern, no character pending
    initial begin
        rxValid = 1'b0;
        rxData = 8'hA5;
        {rxParityErr, rxFrameErr, rxBreak} = 3'h0;
    end
    // one character per edge; a gap of 0 keeps valid high for a burst
    task automatic send(input logic [7:0] d, input logic [2:0] f, input int gap);
        rxValid <= 1'b1;
        rxData <= d;
        {rxParityErr, rxFrameErr, rxBreak} <= f;
        @(posedge clk);
        if (gap > 0) begin
            // idle lines move, so a stale character never looks valid
            rxValid <= 1'b0;
            rxData <= ~d;
            {rxParityErr, rxFrameErr, rxBreak} <= ~f;
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ===== common/ulsr_consts.svh
// offsets, field positions and reset values of the line status block
`ifndef ULSR_CONSTS_SVH
`define ULSR_CONSTS_SVH

// register offsets, byte addresses on the plain port
`define ULSR_OFS_RXBUF     4'h0
`define ULSR_OFS_IRQEN     4'h4
`define ULSR_OFS_LSTAT     4'h8
`define ULSR_OFS_MODEM     4'hC
`define ULSR_OFS_FIFOCTL   4'h1
`define ULSR_OFS_EVSTAT    4'h2
`define ULSR_OFS_EVCLR     4'h3
`define ULSR_OFS_EVEN      4'h5

// line status fields
`define ULSR_BIT_DR        0
`define ULSR_BIT_OE        1
`define ULSR_BIT_PE        2
`define ULSR_BIT_FE        3
`define ULSR_BIT_BI        4

// interrupt enable fields
`define ULSR_BIT_RXIE      0
`define ULSR_BIT_LSIE      2

// event status fields
`define ULSR_EV_RXCHAR     0
`define ULSR_EV_OVERRUN    1
`define ULSR_EV_PARITY     2
`define ULSR_EV_W          3

// reset values
`define ULSR_RST_IRQEN     8'h00
`define ULSR_RST_FIFOEN    1'b0

`endif

// ===== common/ulsr_fifo_if.sv
// push and pop signals between the status core and its receive store
`timescale 1ns/1ps
`default_nettype none
interface ulsr_fifo_if;
    import ulsr_pkg::*;
    logic       push;      // write one character
    ulsr_char_t pushChar;  // character to write
    logic       pop;       // drop the head character
    logic       flush;     // empty the store
    ulsr_char_t headChar;  // character at the head
    logic       empty;     // nothing stored
    logic       full;      // no room left
    modport core  (output push, pushChar, pop, flush, input headChar, empty, full);
    modport store (input push, pushChar, pop, flush, output headChar, empty, full);
endinterface
`default_nettype wire

// ===== common/ulsr_pkg.sv
// types shared by the line status block
package ulsr_pkg;
    // one received character with its line flags
    typedef struct packed {
        logic [7:0] data;
        logic       parityErr;
        logic       frameErr;
        logic       breakInd;
    } ulsr_char_t;

    // read-back mux selection
    typedef enum logic [2:0] {
        ULSR_RD_NONE,
        ULSR_RD_RXBUF,
        ULSR_RD_IRQEN,
        ULSR_RD_LSTAT,
        ULSR_RD_MODEM,
        ULSR_RD_FIFOCTL,
        ULSR_RD_EVSTAT,
        ULSR_RD_EVEN
    } ulsr_rdsel_t;
endpackage

// ===== verilog/ulsr_line_status.sv
// receive line status core: data ready, overrun and parity flags with interrupts
// Notes on behaviour
// R1: parity flag at bit 2, interrupts when enabled
// R2: non-FIFO parity set on bad char, read clears
// R3: FIFO parity follows head character
// R4: overrun flag at bit 1, interrupts when enabled
// R5: line status read clears overrun
// R6: non-FIFO overrun when unread character overwritten
// R7: FIFO overrun only when full; char dropped
// R8: overrun shows at once, not at head
// R9: data ready at bit 0, interrupts when enabled
// R10: non-FIFO ready on char in, read clears
// R11: FIFO ready while any unread character remains
// R12: software never writes the modem status register
// R13: status read returns overrun before clearing it
//
// Implementation choices: the register offsets and the strobed register port.
`include "ulsr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ulsr_line_status
    import ulsr_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [31:0] rdData,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxParityErr,
    input  wire logic        rxFrameErr,
    input  wire logic        rxBreak,
    input  wire logic [7:0]  modemStatus,
    output logic             irq,
    output logic             rxDataIrq,
    output logic             lineStatusIrq
);
    // all state of the core
    typedef struct packed {
        ulsr_char_t             holdChar;   // non-FIFO receive buffer
        logic                   holdFull;   // non-FIFO buffer unread
        logic                   overrun;    // sticky overrun flag
        logic                   fifoEn;     // FIFO mode select
        logic [7:0]             irqEnable;  // interrupt enable register
        logic [`ULSR_EV_W-1:0]  evStatus;   // sticky event bits
        logic [`ULSR_EV_W-1:0]  evEnable;   // event interrupt enables
        logic [31:0]            rdData;     // read data, one cycle late
        logic                   irq;        // event interrupt out
        logic                   rxDataIrq;  // data ready request
        logic                   lsIrq;      // line status request
    } ulsr_state_t;

    ulsr_state_t s_q;  // registered state
    ulsr_state_t s_d;  // next state

    ulsr_fifo_if fifo ();

    ulsr_rx_store #(
        .DEPTH (FIFO_DEPTH)
    ) u_store (
        .clk  (clk),
        .rst  (rst),
        .fifo (fifo)
    );

    // decoded accesses
    logic rdRxBuf;    // receive buffer read, consumes a character
    logic rdLstat;    // line status read, clears overrun
    logic wrIrqEn;    // interrupt enable write
    logic wrFifoCtl;  // FIFO mode write
    logic wrEvClr;    // event clear write
    logic wrEvEn;     // event enable write

    assign rdRxBuf   = rdStb && (addr == `ULSR_OFS_RXBUF);
    assign rdLstat   = rdStb && (addr == `ULSR_OFS_LSTAT);
    assign wrIrqEn   = wrStb && (addr == `ULSR_OFS_IRQEN);
    assign wrFifoCtl = wrStb && (addr == `ULSR_OFS_FIFOCTL);
    assign wrEvClr   = wrStb && (addr == `ULSR_OFS_EVCLR);
    assign wrEvEn    = wrStb && (addr == `ULSR_OFS_EVEN);

    // current character and flags, from buffer or FIFO head
    ulsr_char_t curChar;   // character a read would return
    logic       dataReady; // bit 0 value
    logic       parityNow; // bit 2 value
    logic       overrunEv; // overrun happens this cycle
    logic [7:0] lineStat;  // assembled line status

    always_comb begin
        curChar   = s_q.fifoEn ? fifo.headChar : s_q.holdChar;
        // FIFO: ready while anything unread; otherwise buffer full
        dataReady = s_q.fifoEn ? !fifo.empty : s_q.holdFull;  // [R10] [R11]
        // parity follows the character a read would return
        parityNow = dataReady && curChar.parityErr;           // [R2] [R3]
        // FIFO full: new character is dropped, never pushed
        overrunEv = rxValid && (s_q.fifoEn ? fifo.full : s_q.holdFull);  // [R6] [R7]
        lineStat  = 8'h00;
        lineStat[`ULSR_BIT_DR] = dataReady;                   // [R9]
        lineStat[`ULSR_BIT_OE] = s_q.overrun;                 // [R4]
        lineStat[`ULSR_BIT_PE] = parityNow;                   // [R1]
        lineStat[`ULSR_BIT_FE] = dataReady && curChar.frameErr;
        lineStat[`ULSR_BIT_BI] = dataReady && curChar.breakInd;
    end

    // store drive: push only when room, pop on buffer read
    assign fifo.push     = s_q.fifoEn && rxValid && !fifo.full;  // [R7]
    assign fifo.pushChar = '{data: rxData, parityErr: rxParityErr,
                             frameErr: rxFrameErr, breakInd: rxBreak};
    assign fifo.pop      = s_q.fifoEn && rdRxBuf;                // [R3] [R11]
    assign fifo.flush    = wrFifoCtl;

    // next state of the core
    always_comb begin
        logic [`ULSR_EV_W-1:0] evSet;
        evSet = '0;
        s_d   = s_q;
        // non-FIFO buffer: read empties, new character overwrites
        if (rdRxBuf && !s_q.fifoEn) begin
            s_d.holdFull = 1'b0;  // [R2] [R10]
        end
        if (rxValid && !s_q.fifoEn) begin
            s_d.holdChar = fifo.pushChar;  // [R6]
            s_d.holdFull = 1'b1;           // [R10]
        end
        // overrun: read clears, a new overrun in the same cycle wins
        if (rdLstat) begin
            s_d.overrun = 1'b0;  // [R5]
        end
        if (overrunEv) begin
            s_d.overrun = 1'b1;  // [R8]
        end
        // software registers
        if (wrIrqEn) begin
            s_d.irqEnable = wrData[7:0];
        end
        if (wrFifoCtl) begin
            s_d.fifoEn   = wrData[0];
            s_d.holdFull = 1'b0;
        end
        if (wrEvEn) begin
            s_d.evEnable = wrData[`ULSR_EV_W-1:0];
        end
        // sticky events; set beats clear
        evSet[`ULSR_EV_RXCHAR]  = rxValid;
        evSet[`ULSR_EV_OVERRUN] = overrunEv;
        evSet[`ULSR_EV_PARITY]  = rxValid && rxParityErr;
        if (wrEvClr) begin
            s_d.evStatus = s_q.evStatus & ~wrData[`ULSR_EV_W-1:0];
        end
        s_d.evStatus = s_d.evStatus | evSet;
        // read data sampled from the pre-read state
        s_d.rdData = 32'h0000_0000;
        if (rdStb) begin
            case (addr)
                `ULSR_OFS_RXBUF:   s_d.rdData = {24'h00_0000, curChar.data};
                `ULSR_OFS_IRQEN:   s_d.rdData = {24'h00_0000, s_q.irqEnable};
                `ULSR_OFS_LSTAT:   s_d.rdData = {24'h00_0000, lineStat};  // [R13]
                `ULSR_OFS_MODEM:   s_d.rdData = {24'h00_0000, modemStatus};
                `ULSR_OFS_FIFOCTL: s_d.rdData = {31'h0000_0000, s_q.fifoEn};
                `ULSR_OFS_EVSTAT:  s_d.rdData = {29'h0000_0000, s_q.evStatus};
                `ULSR_OFS_EVEN:    s_d.rdData = {29'h0000_0000, s_q.evEnable};
                default:           s_d.rdData = 32'h0000_0000;
            endcase
        end
        // event request follows the flags that will stand next cycle; data ready and line status requests follow the current flags
        s_d.irq = |(s_d.evStatus & s_d.evEnable);
        s_d.rxDataIrq = s_q.irqEnable[`ULSR_BIT_RXIE] && dataReady;  // [R9]
        s_d.lsIrq = s_q.irqEnable[`ULSR_BIT_LSIE]
                    && (s_q.overrun || parityNow
                        || lineStat[`ULSR_BIT_FE] || lineStat[`ULSR_BIT_BI]);  // [R1] [R4]
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q           <= '0;
            s_q.fifoEn    <= `ULSR_RST_FIFOEN;
            s_q.irqEnable <= `ULSR_RST_IRQEN;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign rdData        = s_q.rdData;
    assign irq           = s_q.irq;
    assign rxDataIrq     = s_q.rxDataIrq;
    assign lineStatusIrq = s_q.lsIrq;

    // checks on flags and requests, all on the one clock, off in reset

    // read-only places: a write there must leave the setup alone
    a_ro_write_ignored: assert property (@(posedge clk) disable iff (rst)  // [R12]
        wrStb && (addr == `ULSR_OFS_MODEM || addr == `ULSR_OFS_LSTAT)
        |=> $stable(s_q.irqEnable) && $stable(s_q.fifoEn) && $stable(s_q.evEnable))
        else $error("read-only place took a write");

    // overrun seen at once, not when its slot reaches the head
    a_overrun_set: assert property (@(posedge clk) disable iff (rst)  // [R8]
        overrunEv
        |=> s_q.overrun)
        else $error("overrun not flagged");

    // status read clears unless a new overrun lands together
    a_overrun_clear: assert property (@(posedge clk) disable iff (rst)  // [R5]
        rdLstat && !overrunEv
        |=> !s_q.overrun)
        else $error("overrun not cleared");

    // the clearing read still returns the flag
    a_overrun_readback: assert property (@(posedge clk) disable iff (rst)  // [R13]
        rdLstat && s_q.overrun
        |=> rdData[`ULSR_BIT_OE])
        else $error("overrun lost");

    // full store: extra character dropped, store stays full, overrun set
    a_fifo_no_push: assert property (@(posedge clk) disable iff (rst)  // [R7]
        s_q.fifoEn && fifo.full && rxValid && !rdRxBuf && !wrFifoCtl
        |=> fifo.full && s_q.overrun)
        else $error("full store took a character");

    // buffer overwrite before the read
    a_nonfifo_overrun: assert property (@(posedge clk) disable iff (rst)  // [R6]
        !s_q.fifoEn && s_q.holdFull && rxValid && !wrFifoCtl
        |=> s_q.overrun)
        else $error("buffer overwrite missed");

    // data ready request follows its enable
    a_ready_irq: assert property (@(posedge clk) disable iff (rst)  // [R9]
        s_q.irqEnable[`ULSR_BIT_RXIE] && dataReady
        |=> rxDataIrq)
        else $error("data ready irq missing");

    // parity request follows its enable
    a_parity_irq: assert property (@(posedge clk) disable iff (rst)  // [R1]
        s_q.irqEnable[`ULSR_BIT_LSIE] && parityNow
        |=> lineStatusIrq)
        else $error("parity irq missing");

    // a buffer read empties the buffer
    a_nonfifo_read: assert property (@(posedge clk) disable iff (rst)  // [R10]
        !s_q.fifoEn && rdRxBuf && !rxValid && !wrFifoCtl
        |=> !s_q.holdFull)
        else $error("read did not empty buffer");

    // first character into an empty store raises ready
    a_fifo_ready: assert property (@(posedge clk) disable iff (rst)  // [R11]
        s_q.fifoEn && fifo.empty && fifo.push && !wrFifoCtl
        |=> !fifo.empty)
        else $error("ready not raised");

    // overrun request follows its enable
    a_overrun_irq: assert property (@(posedge clk) disable iff (rst)  // [R4]
        s_q.irqEnable[`ULSR_BIT_LSIE] && s_q.overrun
        |=> lineStatusIrq)
        else $error("overrun irq missing");

    // masked data ready never requests
    a_ready_irq_off: assert property (@(posedge clk) disable iff (rst)  // [R9]
        !s_q.irqEnable[`ULSR_BIT_RXIE]
        |=> !rxDataIrq)
        else $error("masked data ready irq");

    // masked line status never requests
    a_ls_irq_off: assert property (@(posedge clk) disable iff (rst)  // [R1]
        !s_q.irqEnable[`ULSR_BIT_LSIE]
        |=> !lineStatusIrq)
        else $error("masked line status irq");

    // status read returns ready as it stood at the strobe
    a_status_ready_bit: assert property (@(posedge clk) disable iff (rst)  // [R9]
        rdLstat
        |=> rdData[`ULSR_BIT_DR] == $past(dataReady))
        else $error("ready bit misread");

    // status read returns parity as it stood at the strobe
    a_status_parity_bit: assert property (@(posedge clk) disable iff (rst)  // [R1]
        rdLstat
        |=> rdData[`ULSR_BIT_PE] == $past(parityNow))
        else $error("parity bit misread");

    // status read returns overrun as it stood at the strobe
    a_status_overrun_bit: assert property (@(posedge clk) disable iff (rst)  // [R4]
        rdLstat
        |=> rdData[`ULSR_BIT_OE] == $past(s_q.overrun))
        else $error("overrun bit misread");

    // read data stand one cycle only, zero otherwise
    a_rddata_idle: assert property (@(posedge clk) disable iff (rst)  // [R13]
        !rdStb
        |=> rdData == 32'h0000_0000)
        else $error("read data left standing");

    // ready stays while anything unread remains
    a_ready_holds: assert property (@(posedge clk) disable iff (rst)  // [R11]
        s_q.fifoEn && !fifo.empty && !fifo.pop && !fifo.flush
        |=> !fifo.empty)
        else $error("ready dropped early");

    // no push, no ready
    a_empty_stays: assert property (@(posedge clk) disable iff (rst)  // [R11]
        s_q.fifoEn && fifo.empty && !fifo.push
        |=> fifo.empty)
        else $error("ready without a character");

    // buffer fills on every arrival
    a_nonfifo_ready_set: assert property (@(posedge clk) disable iff (rst)  // [R10]
        !s_q.fifoEn && rxValid && !wrFifoCtl
        |=> s_q.holdFull)
        else $error("ready not set");

    // bad character in the buffer shows parity
    a_nonfifo_parity_set: assert property (@(posedge clk) disable iff (rst)  // [R2]
        !s_q.fifoEn && rxValid && rxParityErr && !wrFifoCtl
        |=> parityNow)
        else $error("parity not set");

    // reading the bad character clears parity
    a_nonfifo_parity_clear: assert property (@(posedge clk) disable iff (rst)  // [R2]
        !s_q.fifoEn && rdRxBuf && !rxValid && !wrFifoCtl
        |=> !parityNow)
        else $error("parity not cleared");

    // bad character landing at an empty head shows parity
    a_fifo_parity_head: assert property (@(posedge clk) disable iff (rst)  // [R3]
        s_q.fifoEn && fifo.empty && fifo.push && rxParityErr && !wrFifoCtl
        |=> parityNow)
        else $error("head parity missed");

    // store mode flags overrun only when full
    a_overrun_only_full: assert property (@(posedge clk) disable iff (rst)  // [R7]
        s_q.fifoEn && !fifo.full && !s_q.overrun
        |=> !s_q.overrun)
        else $error("overrun without full store");

    // only a status read takes overrun away
    a_overrun_holds: assert property (@(posedge clk) disable iff (rst)  // [R5]
        s_q.overrun && !rdLstat
        |=> s_q.overrun)
        else $error("overrun vanished");

endmodule
`default_nettype wire

// ===== verilog/ulsr_rx_store.sv
// receive character store, a circular buffer of flip-flops
`timescale 1ns/1ps
`default_nettype none
module ulsr_rx_store
    import ulsr_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic   clk,
    input  wire logic   rst,
    ulsr_fifo_if.store  fifo
);
    localparam int AW = $clog2(DEPTH);

    // all state of the store
    typedef struct packed {
        ulsr_char_t [DEPTH-1:0] mem;
        logic [AW-1:0]          wrPtr;
        logic [AW-1:0]          rdPtr;
        logic [AW:0]            count;
    } ulsr_store_t;

    ulsr_store_t s_q;  // registered state
    ulsr_store_t s_d;  // next state

    // push when room, pop when data; both at once keeps count
    always_comb begin
        logic doPush;
        logic doPop;
        doPush = 1'b0;
        doPop  = 1'b0;
        s_d    = s_q;
        doPush = fifo.push && !fifo.full;
        doPop  = fifo.pop && !fifo.empty;
        if (doPush) begin
            s_d.mem[s_q.wrPtr] = fifo.pushChar;
            s_d.wrPtr = (s_q.wrPtr == AW'(DEPTH - 1)) ? '0 : s_q.wrPtr + 1'b1;
        end
        if (doPop) begin
            s_d.rdPtr = (s_q.rdPtr == AW'(DEPTH - 1)) ? '0 : s_q.rdPtr + 1'b1;
        end
        if (doPush && !doPop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (doPop && !doPush) begin
            s_d.count = s_q.count - 1'b1;
        end
        // flush wins: contents become unreachable
        if (fifo.flush) begin
            s_d.wrPtr = '0;
            s_d.rdPtr = '0;
            s_d.count = '0;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fifo.headChar = s_q.mem[s_q.rdPtr];
    assign fifo.empty    = (s_q.count == '0);
    assign fifo.full     = (s_q.count == (AW+1)'(DEPTH));
endmodule
`default_nettype wire
